// [design/mkey_keyer.v]
// Functional notes
// - time sending and ident at configured rate, 5 to 99 wpm, default 20
// - below floor rate, form characters at floor, stretch gaps to reach rate
// - dash is three dots plus weighting times a tenth dot
// - periodic mode sends ident text once every interval of whole minutes
// - idle mode sends ident once after interval with no channel activity
// - interval of zero suppresses all automatic ident
// - automatic ident sends the stored ident text string
// - entering morse mode with a rate adopts it, else stored rate stays
// - key output selected drives key line during each element, unless audio output is also selected
// - audio output, with ptt also selected, gates a tone per element instead of the key line
// - gated tone uses the configured tone frequency, default 750 hz
// - ptt option holds ptt active through each transmission
// - output selection off gives no keying at all
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "mkey_map.vh"
module mkey_keyer #(
	parameter TICK_CYC  = `MKEY_TICK_CYC,
	parameter MIN_TICKS = `MKEY_MIN_TICKS
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire        channel_activity,
	output reg         key_output_line,
	output reg         ptt_out,
	output wire        tone_out
);
	// ==========================================
	// states
	localparam [4:0] ST_IDLE = 5'b00001;
	localparam [4:0] ST_ELEM = 5'b00010;
	localparam [4:0] ST_EGAP = 5'b00100;
	localparam [4:0] ST_CGAP = 5'b01000;
	localparam [4:0] ST_WGAP = 5'b10000;

	// ==========================================
	// registers
	reg  [4:0]  ctrl_q;
	reg  [6:0]  morse_rate_q;
	reg  [6:0]  char_rate_floor_q;
	reg  [3:0]  dash_weighting_q;
	reg  [7:0]  auto_ident_interval_q;
	reg  [3:0]  ident_len_q;
	reg  [10:0] tone_frequency_q;
	reg  [7:0]  hold_q;
	reg         hold_v_q;
	reg  [7:0]  ident_text [0:`MKEY_TEXT_LEN-1];
	reg  [4:0]  st_q;
	reg  [5:0]  code_q;
	reg  [2:0]  len_q;
	reg  [7:0]  tenth_q;
	reg  [15:0] unit_q;
	reg  [3:0]  idx_q;
	reg         ident_act_q;
	reg         ident_req_q;
	reg         after_done_q;
	reg  [19:0] min_cnt_q;
	reg  [7:0]  mins_q;
	reg  [15:0] char_per_q;
	reg  [15:0] gap_per_q;
	reg  [31:0] rdata;
	integer     i;

	wire        tick;
	wire        wr_en = psel & penable & pwrite;
	wire        text_hit = (paddr[7:4] == `MKEY_TEXT_HI) & (paddr[1:0] == 2'b00);
	wire [3:0]  text_base = {paddr[3:2], 2'b00};
	wire        hit = (paddr == `MKEY_CTRL_OFS) | (paddr == `MKEY_RATE_OFS) |
	                  (paddr == `MKEY_IDENT_OFS) | (paddr == `MKEY_TONE_OFS) |
	                  (paddr == `MKEY_TXDATA_OFS) | (paddr == `MKEY_STATUS_OFS) |
	                  (paddr == `MKEY_ENTER_OFS) | text_hit;

	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~hit;

	// ==========================================
	// sub blocks
	mkey_timebase #(
		.TICK_CYC (TICK_CYC)
	) u_tb (
		.pclk    (pclk),
		.presetn (presetn),
		.tick_q  (tick)
	);

	mkey_tone u_tone (
		.pclk    (pclk),
		.presetn (presetn),
		.gate    ((st_q == ST_ELEM) & ctrl_q[`MKEY_CTRL_AUDIO] & ctrl_q[`MKEY_CTRL_PTT]),
		.freq    (tone_frequency_q),
		.tone_q  (tone_out)
	);

	// ==========================================
	// character lookup: {length, pattern msb first, 1 = dash}
	function [8:0] mkey_code;
		input [7:0] c;
		reg   [7:0] u;
		begin
			u = (c >= 8'h61 && c <= 8'h7a) ? c - 8'h20 : c;
			case (u)
			8'h41: mkey_code = {3'h2, 6'b010000};
			8'h42: mkey_code = {3'h4, 6'b100000};
			8'h43: mkey_code = {3'h4, 6'b101000};
			8'h44: mkey_code = {3'h3, 6'b100000};
			8'h45: mkey_code = {3'h1, 6'b000000};
			8'h46: mkey_code = {3'h4, 6'b001000};
			8'h47: mkey_code = {3'h3, 6'b110000};
			8'h48: mkey_code = {3'h4, 6'b000000};
			8'h49: mkey_code = {3'h2, 6'b000000};
			8'h4a: mkey_code = {3'h4, 6'b011100};
			8'h4b: mkey_code = {3'h3, 6'b101000};
			8'h4c: mkey_code = {3'h4, 6'b010000};
			8'h4d: mkey_code = {3'h2, 6'b110000};
			8'h4e: mkey_code = {3'h2, 6'b100000};
			8'h4f: mkey_code = {3'h3, 6'b111000};
			8'h50: mkey_code = {3'h4, 6'b011000};
			8'h51: mkey_code = {3'h4, 6'b110100};
			8'h52: mkey_code = {3'h3, 6'b010000};
			8'h53: mkey_code = {3'h3, 6'b000000};
			8'h54: mkey_code = {3'h1, 6'b100000};
			8'h55: mkey_code = {3'h3, 6'b001000};
			8'h56: mkey_code = {3'h4, 6'b000100};
			8'h57: mkey_code = {3'h3, 6'b011000};
			8'h58: mkey_code = {3'h4, 6'b100100};
			8'h59: mkey_code = {3'h4, 6'b101100};
			8'h5a: mkey_code = {3'h4, 6'b110000};
			8'h30: mkey_code = {3'h5, 6'b111110};
			8'h31: mkey_code = {3'h5, 6'b011110};
			8'h32: mkey_code = {3'h5, 6'b001110};
			8'h33: mkey_code = {3'h5, 6'b000110};
			8'h34: mkey_code = {3'h5, 6'b000010};
			8'h35: mkey_code = {3'h5, 6'b000000};
			8'h36: mkey_code = {3'h5, 6'b100000};
			8'h37: mkey_code = {3'h5, 6'b110000};
			8'h38: mkey_code = {3'h5, 6'b111000};
			8'h39: mkey_code = {3'h5, 6'b111100};
			8'h2f: mkey_code = {3'h5, 6'b100100};
			8'h3f: mkey_code = {3'h6, 6'b001100};
			8'h2e: mkey_code = {3'h6, 6'b010101};
			8'h2c: mkey_code = {3'h6, 6'b110011};
			// space and unknown characters become a word gap
			default: mkey_code = {3'h0, 6'b000000};
			endcase
		end
	endfunction

	function [6:0] mkey_clamp;
		input [6:0] r;
		begin
			if (r < `MKEY_RATE_MIN)
				mkey_clamp = `MKEY_RATE_MIN;
			else if (r > `MKEY_RATE_MAX)
				mkey_clamp = `MKEY_RATE_MAX;
			else
				mkey_clamp = r;
		end
	endfunction

	// ==========================================
	// element timing, recomputed every cycle from the rate registers
	wire [6:0]  rate_eff  = mkey_clamp(morse_rate_q);
	wire [6:0]  floor_eff = mkey_clamp(char_rate_floor_q);
	wire [6:0]  char_eff  = (rate_eff < floor_eff) ? floor_eff : rate_eff;
	wire [31:0] rate_w    = {25'h0000000, rate_eff};
	wire [31:0] char_w    = {25'h0000000, char_eff};
	wire [31:0] char_div  = `MKEY_TENTH_NUM / char_w;
	wire [31:0] word_div  = `MKEY_WORD_NUM / rate_w;
	wire [31:0] part_div  = `MKEY_CHARPT_NUM / char_w;
	wire [31:0] gap_div   = (word_div - part_div) / `MKEY_GAP_DEN;
	wire [7:0]  dash_t    = `MKEY_T_DASH + {4'h0, dash_weighting_q};

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			char_per_q <= 16'h0001;
			gap_per_q  <= 16'h0001;
		end else begin
			char_per_q <= (char_div[15:0] == 16'h0000) ? 16'h0001 : char_div[15:0];
			gap_per_q  <= (gap_div[15:0] == 16'h0000) ? 16'h0001 : gap_div[15:0];
		end
	end

	// ==========================================
	// character source selection
	wire [3:0]  id_len    = ident_len_q;
	wire        id_more   = ident_act_q & (idx_q < id_len);
	wire        id_new    = ~ident_act_q & ident_req_q & (id_len != 4'h0);
	wire        txd_ok    = ctrl_q[`MKEY_CTRL_MODE] & hold_v_q;
	wire        nxt_valid = id_more | id_new | txd_ok;
	wire [7:0]  nxt_char  = id_more ? ident_text[idx_q] :
	                        id_new ? ident_text[0] : hold_q;
	wire [8:0]  nxt_code  = mkey_code(nxt_char);
	wire        is_gap    = (st_q == ST_CGAP) | (st_q == ST_WGAP);
	wire [15:0] per       = is_gap ? gap_per_q : char_per_q;
	wire        unit_end  = tick & (unit_q + 16'h0001 >= per);
	wire        t_end     = unit_end & (tenth_q <= 8'h01);
	wire        ld        = (st_q == ST_IDLE) | (is_gap & t_end);

	// ==========================================
	// ident interval timer
	wire        id_after = ctrl_q[`MKEY_CTRL_AFTER];
	wire        id_off   = (auto_ident_interval_q == 8'h00);
	wire        min_wrap = tick & (min_cnt_q == MIN_TICKS[19:0] - 20'h00001);
	wire        run      = ~id_off & ~(id_after & (channel_activity | after_done_q));
	wire        fire     = run & min_wrap & (mins_q + 8'h01 == auto_ident_interval_q);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			min_cnt_q    <= 20'h00000;
			mins_q       <= 8'h00;
			after_done_q <= 1'b0;
			ident_req_q  <= 1'b0;
		end else begin
			if (!run) begin
				// activity restarts the quiet period and rearms the one-shot
				min_cnt_q <= 20'h00000;
				mins_q    <= 8'h00;
			end else if (min_wrap) begin
				min_cnt_q <= 20'h00000;
				mins_q    <= fire ? 8'h00 : mins_q + 8'h01;
			end else if (tick) begin
				min_cnt_q <= min_cnt_q + 20'h00001;
			end
			if (id_off | ~id_after | channel_activity)
				after_done_q <= 1'b0;
			else if (fire)
				after_done_q <= 1'b1;
			if (id_off)
				ident_req_q <= 1'b0;
			else if (fire)
				ident_req_q <= 1'b1;
			else if (ld & id_new)
				ident_req_q <= 1'b0;
		end
	end

	// ==========================================
	// element sequencer
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q        <= ST_IDLE;
			code_q      <= 6'h00;
			len_q       <= 3'h0;
			tenth_q     <= 8'h00;
			unit_q      <= 16'h0000;
			idx_q       <= 4'h0;
			ident_act_q <= 1'b0;
		end else begin
			if (unit_end)
				unit_q <= 16'h0000;
			else if (tick)
				unit_q <= unit_q + 16'h0001;
			if (ld) begin
				unit_q <= 16'h0000;
				if (nxt_valid) begin
					if (id_more)
						idx_q <= idx_q + 4'h1;
					else if (id_new)
						idx_q <= 4'h1;
					ident_act_q <= id_more | id_new;
					code_q      <= nxt_code[5:0];
					len_q       <= nxt_code[8:6];
					if (nxt_code[8:6] == 3'h0) begin
						// word gap: three already spent after the last character
						st_q    <= ST_WGAP;
						tenth_q <= `MKEY_T_WEXTRA;
					end else begin
						st_q    <= ST_ELEM;
						tenth_q <= nxt_code[5] ? dash_t : `MKEY_T_DOT;
					end
				end else begin
					st_q        <= ST_IDLE;
					ident_act_q <= 1'b0;
				end
			end else if (unit_end) begin
				if (!t_end) begin
					tenth_q <= tenth_q - 8'h01;
				end else begin
					case (st_q)
					ST_ELEM: begin
						if (len_q > 3'h1) begin
							st_q    <= ST_EGAP;
							tenth_q <= `MKEY_T_EGAP;
							code_q  <= {code_q[4:0], 1'b0};
							len_q   <= len_q - 3'h1;
						end else begin
							st_q    <= ST_CGAP;
							tenth_q <= `MKEY_T_CGAP;
						end
					end
					ST_EGAP: begin
						st_q    <= ST_ELEM;
						tenth_q <= code_q[5] ? dash_t : `MKEY_T_DOT;
					end
					default: begin
						st_q    <= ST_IDLE;
						tenth_q <= 8'h00;
					end
					endcase
				end
			end
		end
	end

	// ==========================================
	// transmit outputs
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			key_output_line <= 1'b0;
			ptt_out         <= 1'b0;
		end else begin
			// audio drops the key line, its tone also needs ptt; all selects off keys nothing
			key_output_line <= (st_q == ST_ELEM) & ctrl_q[`MKEY_CTRL_KEY] &
			                   ~ctrl_q[`MKEY_CTRL_AUDIO];
			ptt_out         <= (st_q != ST_IDLE) & ctrl_q[`MKEY_CTRL_PTT];
		end
	end

	// ==========================================
	// apb register file
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q                <= `MKEY_CTRL_RST;
			morse_rate_q          <= `MKEY_RATE_RST;
			char_rate_floor_q     <= `MKEY_FLOOR_RST;
			dash_weighting_q      <= `MKEY_WEIGHT_RST;
			auto_ident_interval_q <= 8'h00;
			ident_len_q           <= 4'h0;
			tone_frequency_q      <= `MKEY_TONE_RST;
			hold_q                <= 8'h00;
			hold_v_q              <= 1'b0;
			for (i = 0; i < `MKEY_TEXT_LEN; i = i + 1)
				ident_text[i] <= 8'h00;
		end else begin
			if (ld & ~id_more & ~id_new & txd_ok)
				hold_v_q <= 1'b0;
			if (wr_en) begin
				case (paddr)
				`MKEY_CTRL_OFS: ctrl_q <= pwdata[4:0];
				`MKEY_RATE_OFS: begin
					morse_rate_q      <= pwdata[6:0];
					char_rate_floor_q <= pwdata[14:8];
					dash_weighting_q  <= pwdata[19:16];
				end
				`MKEY_IDENT_OFS: begin
					auto_ident_interval_q <= pwdata[7:0];
					ident_len_q           <= pwdata[19:16];
				end
				`MKEY_TONE_OFS: tone_frequency_q <= pwdata[10:0];
				`MKEY_TXDATA_OFS: begin
					// a full holding register ignores the write
					if (!hold_v_q) begin
						hold_q   <= pwdata[7:0];
						hold_v_q <= 1'b1;
					end
				end
				`MKEY_ENTER_OFS: begin
					ctrl_q[`MKEY_CTRL_MODE] <= 1'b1;
					if (pwdata[31:7] == 25'h0000000 && pwdata[6:0] >= `MKEY_RATE_MIN &&
					    pwdata[6:0] <= `MKEY_RATE_MAX)
						morse_rate_q <= pwdata[6:0];
				end
				default: begin
					if (text_hit) begin
						ident_text[text_base]        <= pwdata[7:0];
						ident_text[text_base + 4'h1] <= pwdata[15:8];
						ident_text[text_base + 4'h2] <= pwdata[23:16];
						ident_text[text_base + 4'h3] <= pwdata[31:24];
					end
				end
				endcase
			end
		end
	end

	always @* begin
		rdata = 32'h00000000;
		case (paddr)
		`MKEY_CTRL_OFS:   rdata = {27'h0000000, ctrl_q};
		`MKEY_RATE_OFS:   rdata = {12'h000, dash_weighting_q, 1'b0, char_rate_floor_q,
		                           1'b0, morse_rate_q};
		`MKEY_IDENT_OFS:  rdata = {12'h000, ident_len_q, 8'h00, auto_ident_interval_q};
		`MKEY_TONE_OFS:   rdata = {21'h000000, tone_frequency_q};
		`MKEY_TXDATA_OFS: rdata = {24'h000000, hold_q};
		`MKEY_STATUS_OFS: rdata = {27'h0000000, st_q == ST_ELEM, ident_req_q, hold_v_q,
		                           ident_act_q, st_q != ST_IDLE};
		default: begin
			if (text_hit)
				rdata = {ident_text[text_base + 4'h3], ident_text[text_base + 4'h2],
				         ident_text[text_base + 4'h1], ident_text[text_base]};
		end
		endcase
	end

	// read data captured in the setup phase so the access phase needs no wait
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (psel & ~penable & ~pwrite)
			prdata <= rdata;
	end
endmodule

// [design/mkey_map.vh]
`ifndef MKEY_MAP_VH
`define MKEY_MAP_VH
// ==========================================
// register offsets (byte addresses)
`define MKEY_CTRL_OFS     8'h00
`define MKEY_RATE_OFS     8'h04
`define MKEY_IDENT_OFS    8'h08
`define MKEY_TONE_OFS     8'h0c
`define MKEY_TXDATA_OFS   8'h10
`define MKEY_STATUS_OFS   8'h14
`define MKEY_ENTER_OFS    8'h18
`define MKEY_TEXT_OFS     8'h20
`define MKEY_TEXT_HI      4'h2
// ==========================================
// control fields
`define MKEY_CTRL_KEY     0
`define MKEY_CTRL_PTT     1
`define MKEY_CTRL_AUDIO   2
`define MKEY_CTRL_MODE    3
`define MKEY_CTRL_AFTER   4
`define MKEY_CTRL_RST     5'h01
// ==========================================
// rate and ident fields, reset values
`define MKEY_RATE_RST     7'h14
`define MKEY_FLOOR_RST    7'h0f
`define MKEY_WEIGHT_RST   4'h0
`define MKEY_RATE_MIN     7'h05
`define MKEY_RATE_MAX     7'h63
`define MKEY_TONE_RST     11'h2ee
`define MKEY_TEXT_LEN     16
// ==========================================
// timing
`define MKEY_CLK_HZ       20000000
`define MKEY_TICK_US      100
`define MKEY_TICK_CYC     (`MKEY_CLK_HZ / 1000000 * `MKEY_TICK_US)
`define MKEY_MIN_MS       60000
`define MKEY_MIN_TICKS    (`MKEY_MIN_MS * 1000 / `MKEY_TICK_US)
`define MKEY_DOT_MS       1200
`define MKEY_TENTH_NUM    (`MKEY_DOT_MS * 1000 / `MKEY_TICK_US / 10)
`define MKEY_WORD_NUM     (`MKEY_TENTH_NUM * 500)
`define MKEY_CHARPT_NUM   (`MKEY_TENTH_NUM * 310)
`define MKEY_GAP_DEN      190
// element lengths in tenths of a dot
`define MKEY_T_DOT        8'h0a
`define MKEY_T_DASH       8'h1e
`define MKEY_T_EGAP       8'h0a
`define MKEY_T_CGAP       8'h1e
`define MKEY_T_WEXTRA     8'h28
// nco step per hz: 2^32 / clock rate
`define MKEY_NCO_SCALE    32'h000000d7
`endif

// [design/mkey_timebase.v]
`timescale 1ns/1ps
`include "mkey_map.vh"
module mkey_timebase #(
	parameter TICK_CYC = `MKEY_TICK_CYC
) (
	input  wire pclk,
	input  wire presetn,
	output reg  tick_q
);
	reg [15:0] cnt_q;
	wire       wrap = (cnt_q == TICK_CYC[15:0] - 16'h0001);
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q  <= 16'h0000;
			tick_q <= 1'b0;
		end else begin
			cnt_q  <= wrap ? 16'h0000 : cnt_q + 16'h0001;
			tick_q <= wrap;
		end
	end
endmodule

// [design/mkey_tone.v]
`timescale 1ns/1ps
`include "mkey_map.vh"
module mkey_tone (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        gate,
	input  wire [10:0] freq,
	output reg         tone_q
);
	reg  [31:0] acc_q;
	wire [31:0] inc = {21'h000000, freq} * `MKEY_NCO_SCALE;
	// phase restarts each element so every element begins on the same edge
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_q  <= 32'h00000000;
			tone_q <= 1'b0;
		end else begin
			acc_q  <= gate ? acc_q + inc : 32'h00000000;
			tone_q <= gate & acc_q[31];
		end
	end
endmodule

// [tb/mkey_keyer_monitor.sv]
`timescale 1ns/1ps
`include "mkey_map.vh"
// ==========================================
// port checker, shadows ctrl and rate writes
module mkey_keyer_monitor #(
	parameter TICK_CYC = 4
) (
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [7:0]  paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	input wire        channel_activity,
	input wire        key_output_line,
	input wire        ptt_out,
	input wire        tone_out
);
	logic [4:0] ctrl_q;
	logic [6:0] rate_q;
	logic [6:0] floor_q;
	logic [3:0] wt_q;
	int         kcnt_q;
	int         t_c;
	logic       wr;
	logic       mapped;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	function automatic int clampr(input logic [6:0] r);
		return (r < 5) ? 5 : ((r > 99) ? 99 : int'(r));
	endfunction
	function automatic bit near(input int a, input int b);
		return (a - b <= TICK_CYC + 1) && (b - a <= TICK_CYC + 1);
	endfunction
	assign wr = psel && penable && pwrite;
	assign mapped = paddr[1:0] == 2'h0 && (paddr <= 8'h18 || (paddr >= 8'h20 && paddr <= 8'h2c));
	// tenth of a dot in clocks at the character rate
	always_comb begin
		t_c = 1200 / ((clampr(rate_q) < clampr(floor_q)) ? clampr(floor_q) : clampr(rate_q));
		t_c = t_c * TICK_CYC;
	end
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `MKEY_CTRL_RST;
			rate_q <= `MKEY_RATE_RST;
			floor_q <= `MKEY_FLOOR_RST;
			wt_q <= `MKEY_WEIGHT_RST;
			kcnt_q <= 0;
		end else begin
			kcnt_q <= key_output_line ? kcnt_q + 1 : 0;
			if (wr && paddr == `MKEY_CTRL_OFS) ctrl_q <= pwdata[4:0];
			if (wr && paddr == `MKEY_ENTER_OFS) ctrl_q[3] <= 1'b1;
			if (wr && paddr == `MKEY_ENTER_OFS && pwdata >= 5 && pwdata <= 99) rate_q <= pwdata[6:0];
			if (wr && paddr == `MKEY_RATE_OFS) begin
				rate_q <= pwdata[6:0];
				floor_q <= pwdata[14:8];
				wt_q <= pwdata[19:16];
			end
		end
	end
	// ==========================================
	// sequences
	sequence txd_load;
		wr && paddr == `MKEY_TXDATA_OFS && pwdata[7:0] == 8'h45 && ctrl_q == 5'h0b && !ptt_out;
	endsequence
	sequence key_soon;
		##[1:3] key_output_line;
	endsequence
	// ==========================================
	// assertions
	slverr_map_a: assert property (pslverr == (psel && penable && !mapped))
		else $error("pslverr does not follow the address map");
	unmap_read_a: assert property (psel && penable && !pwrite && !mapped |-> prdata == 32'h0)
		else $error("unmapped read returned data");
	key_select_a: assert property (key_output_line |-> ctrl_q[0] && !ctrl_q[2])
		else $error("key line active without key selection");
	ptt_select_a: assert property ($rose(ptt_out) |-> ctrl_q[1])
		else $error("ptt raised without ptt selection");
	ptt_cover_a: assert property (key_output_line && ctrl_q[1] |-> ptt_out)
		else $error("ptt low during an element");
	tone_gate_a: assert property ($rose(tone_out) |-> ctrl_q[2] && ctrl_q[1])
		else $error("tone runs without audio and ptt");
	key_start_a: assert property (txd_load |-> key_soon)
		else $error("key did not follow the character write");
	elem_len_a: assert property ($fell(key_output_line) |-> near(kcnt_q, 10 * t_c) || near(kcnt_q, (30 + wt_q) * t_c))
		else $error("element is neither a dot nor a weighted dash");
endmodule

// [tb/mkey_radio.sv]
`timescale 1ns/1ps
// ==========================================
// transceiver side: times key, ptt and tone
module mkey_radio (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        key_in,
	input  wire        ptt_in,
	input  wire        tone_in,
	output logic [2:0] done_q,
	output int         len_q [3],
	output int         key_count,
	output int         ptt_count
);
	logic [2:0] last_q;
	int         cnt_q [3];
	logic       seen_q;
	wire  [2:0] now = {tone_in, ptt_in, key_in};
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_q <= 3'h0;
			done_q <= 3'h0;
			seen_q <= 1'b0;
			key_count <= 0;
			ptt_count <= 0;
			for (int i = 0; i < 3; i++) begin
				cnt_q[i] <= 0;
				len_q[i] <= 0;
			end
		end else begin
			last_q <= now;
			for (int i = 0; i < 2; i++) begin
				cnt_q[i] <= now[i] ? cnt_q[i] + 1 : 0;
				done_q[i] <= last_q[i] && !now[i];
				if (last_q[i] && !now[i]) len_q[i] <= cnt_q[i];
			end
			if (last_q[0] && !now[0]) key_count <= key_count + 1;
			if (last_q[1] && !now[1]) ptt_count <= ptt_count + 1;
			// first toggle only starts the clock; halves are timed after it
			cnt_q[2] <= (now[2] != last_q[2]) ? 1 : cnt_q[2] + 1;
			done_q[2] <= (now[2] != last_q[2]) && seen_q;
			if (now[2] != last_q[2]) len_q[2] <= cnt_q[2];
			if (now[2] != last_q[2]) seen_q <= 1'b1;
		end
	end
endmodule

// [tb/tb.sv]
`timescale 1ns/1ps
`include "mkey_map.vh"
bind mkey_keyer mkey_keyer_monitor #(.TICK_CYC(TICK_CYC)) i_mon (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .channel_activity(channel_activity),
	.key_output_line(key_output_line), .ptt_out(ptt_out), .tone_out(tone_out));
module tb;
	localparam int DOT = 480;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic        channel_activity;
	logic        noted;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] rdata;
	wire  [31:0] prdata;
	wire         pready;
	wire         pslverr;
	wire         key_output_line;
	wire         ptt_out;
	wire         tone_out;
	wire  [2:0]  done;
	int          len [3];
	int          key_count;
	int          ptt_count;
	int          err_count;
	int          tests_run;
	int          seed;
	int          k0;
	int          w;
	logic [31:0] q_rd [$];
	int          q_len [3][$];
	always #25 pclk = ~pclk;
	// short tick and minute keep the run small
	mkey_keyer #(.TICK_CYC(4), .MIN_TICKS(50)) i_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .channel_activity(channel_activity),
		.key_output_line(key_output_line), .ptt_out(ptt_out), .tone_out(tone_out));
	mkey_radio i_radio (.pclk(pclk), .presetn(presetn), .key_in(key_output_line),
		.ptt_in(ptt_out), .tone_in(tone_out), .done_q(done), .len_q(len),
		.key_count(key_count), .ptt_count(ptt_count));
	// ==========================================
	// checking
	task chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
		tests_run++;
		if ((^got === 1'bx) || got < lo || got > hi) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
		end
	endtask
	task expect_len(input int i, input int c, input int t);
		q_len[i].push_back(c - t);
		q_len[i].push_back(c + t);
	endtask
	always @(posedge pclk) begin
		logic [31:0] e;
		int lo;
		if (noted && psel && penable && !pwrite && pready) begin
			e = q_rd.pop_front();
			chk(prdata, e, e);
		end
		for (int i = 0; i < 3; i++) begin
			if (done[i] && q_len[i].size() > 1) begin
				lo = q_len[i].pop_front();
				chk(len[i], lo, q_len[i].pop_front());
			end
		end
	end
	task give_verdict;
		if (q_rd.size() + q_len[0].size() + q_len[1].size() + q_len[2].size() != 0) err_count++;
		$display("counts: %0d checks, %0d mismatches", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ==========================================
	// apb master
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic n);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		noted <= n;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rdata = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		noted <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		q_rd.push_back(e);
		apb(1'b0, a, 32'h0, 1'b1);
	endtask
	task wait_idle;
		int n;
		n = 0;
		do begin
			repeat (40) @(posedge pclk);
			apb(1'b0, `MKEY_STATUS_OFS, 32'h0, 1'b0);
			n++;
		end while (rdata[3:0] !== 4'h0 && n < 1000);
		chk(n < 1000, 1, 1);
	endtask
	initial begin
		repeat (90000) @(posedge pclk);
		err_count++;
		give_verdict;
	end
	initial begin
		pclk = 0;
		presetn = 0;
		{psel, penable, pwrite, channel_activity, noted} = 5'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		seed = 9;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rd(`MKEY_CTRL_OFS, 32'h1);
		rd(`MKEY_RATE_OFS, 32'h0f14);
		rd(`MKEY_IDENT_OFS, 32'h0);
		rd(`MKEY_TONE_OFS, 32'h2ee);
		rd(8'h1c, 32'h0);
		apb(1'b1, `MKEY_ENTER_OFS, 32'h63, 1'b0);
		rd(`MKEY_RATE_OFS, 32'h0f63);
		apb(1'b1, `MKEY_ENTER_OFS, 32'hc8, 1'b0);
		rd(`MKEY_RATE_OFS, 32'h0f63);
		rd(`MKEY_CTRL_OFS, 32'h9);
		$display("test registers done");
		apb(1'b1, `MKEY_CTRL_OFS, 32'h0b, 1'b0);
		expect_len(0, DOT, 5);
		expect_len(1, 4 * DOT, 10);
		apb(1'b1, `MKEY_TXDATA_OFS, 32'h45, 1'b0);
		wait_idle;
		w = $unsigned($random(seed)) % 16;
		apb(1'b1, `MKEY_RATE_OFS, {12'h0, w[3:0], 16'h0f63}, 1'b0);
		expect_len(0, (30 + w) * 48, 5);
		expect_len(1, (60 + w) * 48, 10);
		apb(1'b1, `MKEY_TXDATA_OFS, 32'h54, 1'b0);
		wait_idle;
		apb(1'b1, `MKEY_RATE_OFS, 32'h0f78, 1'b0);
		rd(`MKEY_RATE_OFS, 32'h0f78);
		expect_len(0, DOT, 5);
		apb(1'b1, `MKEY_TXDATA_OFS, 32'h45, 1'b0);
		wait_idle;
		apb(1'b1, `MKEY_RATE_OFS, 32'h6332, 1'b0);
		expect_len(0, DOT, 5);
		expect_len(1, DOT + 120 * ((600000 / 50 - 372000 / 99) / 190), 60);
		apb(1'b1, `MKEY_TXDATA_OFS, 32'h45, 1'b0);
		wait_idle;
		$display("test timing done");
		apb(1'b1, `MKEY_CTRL_OFS, 32'h08, 1'b0);
		apb(1'b1, `MKEY_RATE_OFS, 32'h0f63, 1'b0);
		k0 = key_count + ptt_count;
		apb(1'b1, `MKEY_TXDATA_OFS, 32'h54, 1'b0);
		wait_idle;
		chk(key_count + ptt_count, k0, k0);
		apb(1'b1, `MKEY_CTRL_OFS, 32'h0e, 1'b0);
		apb(1'b1, `MKEY_TONE_OFS, 32'h7d0, 1'b0);
		apb(1'b1, `MKEY_RATE_OFS, 32'h0c0c, 1'b0);
		expect_len(1, 24000, 10);
		expect_len(2, 4994, 3);
		k0 = key_count;
		apb(1'b1, `MKEY_TXDATA_OFS, 32'h54, 1'b0);
		wait_idle;
		chk(key_count, k0, k0);
		$display("test outputs done");
		apb(1'b1, `MKEY_CTRL_OFS, 32'h09, 1'b0);
		apb(1'b1, `MKEY_RATE_OFS, 32'h0f63, 1'b0);
		apb(1'b1, `MKEY_TEXT_OFS, 32'h45, 1'b0);
		k0 = key_count;
		apb(1'b1, `MKEY_IDENT_OFS, 32'h10001, 1'b0);
		repeat (4500) @(posedge pclk);
		chk(key_count, k0 + 2, k0 + 3);
		apb(1'b1, `MKEY_IDENT_OFS, 32'h0, 1'b0);
		wait_idle;
		k0 = key_count;
		repeat (3000) @(posedge pclk);
		chk(key_count, k0, k0);
		apb(1'b1, `MKEY_TEXT_OFS, 32'h54, 1'b0);
		apb(1'b1, `MKEY_CTRL_OFS, 32'h19, 1'b0);
		channel_activity <= 1'b1;
		apb(1'b1, `MKEY_IDENT_OFS, 32'h10001, 1'b0);
		repeat (1000) @(posedge pclk);
		chk(key_count, k0, k0);
		expect_len(0, 1440, 5);
		channel_activity <= 1'b0;
		repeat (4000) @(posedge pclk);
		chk(key_count, k0 + 1, k0 + 1);
		$display("test ident done");
		give_verdict;
	end
endmodule
